// >>> common/ecs_pkg.sv
// constants and types for the exception cause status block
// Contract
// RL1 - software writes only request, disable, select, wait bits
// RL2 - external controller mode: pending bits carry priority
// RL3 - bit 31 delay slot, only when level clear
// RL4 - bit 30 shows timer interrupt pending
// RL5 - timer pending drives a core output
// RL6 - bits 29:28 load unit number every exception
// RL7 - bit 27 set stops count, resets 0
// RL8 - bit 26 shows perf interrupt, resets 0
// RL9 - perf pending drives a core output
// RL10 - bit 25 records chaining on interrupt return
// RL11 - bit 24 records fault during auto prologue
// RL12 - bit 23 picks vector 16#180 or 16#200
// RL13 - select set, boot clear: vectored table base
// RL14 - writes to read-only fields are ignored
`default_nettype none
package ecs_pkg;
  // field positions
  localparam int unsigned DELAY_SLOT_BIT     = 31;
  localparam int unsigned TIMER_PEND_BIT     = 30;
  localparam int unsigned COP_UNIT_HI        = 29;
  localparam int unsigned COP_UNIT_LO        = 28;
  localparam int unsigned COUNT_DIS_BIT      = 27;
  localparam int unsigned PERF_PEND_BIT      = 26;
  localparam int unsigned CHAIN_BIT          = 25;
  localparam int unsigned PROLOGUE_BIT       = 24;
  localparam int unsigned VEC_SEL_BIT        = 23;
  localparam int unsigned WAIT_PEND_BIT      = 22;
  localparam int unsigned HW_PEND_HI         = 15;
  localparam int unsigned HW_PEND_LO         = 10;
  localparam int unsigned SW_REQ_HI          = 9;
  localparam int unsigned SW_REQ_LO          = 8;
  // values after reset
  localparam logic        COUNT_DIS_RST      = 1'b0;
  localparam logic        PERF_PEND_RST      = 1'b0;
  localparam logic        FLAG_RST           = 1'b0;
  localparam logic [1:0]  COP_UNIT_RST       = 2'h0;
  localparam logic [1:0]  SW_REQ_RST         = 2'h0;
  localparam logic [31:0] WORD_RST           = 32'h0000_0000;
  // interrupt dispatch offsets
  localparam logic [11:0] GEN_VEC_OFFSET     = 12'h180;
  localparam logic [11:0] SPECIAL_VEC_OFFSET = 12'h200;

  // facts reported by the pipeline when an exception is taken
  typedef struct packed {
    logic       in_delay_slot; // faulting op sat in a delay slot
    logic       level_was_set; // exception level flag at the time
    logic [1:0] cop_unit;      // coprocessor unit referenced
    logic       in_prologue;   // fault hit during auto prologue
  } ecs_exc_info_s;

  // coprocessor register write request
  typedef struct packed {
    logic        wr_en;   // one-cycle write strobe
    logic [31:0] wr_data; // word written by software
  } ecs_wr_req_s;
endpackage : ecs_pkg
`default_nettype wire

// >>> hw/ecs_cause.sv
// exception cause status register with interrupt pending mirrors
`default_nettype none
module ecs_cause
  import ecs_pkg::*;
(
  input  wire logic          core_clk_in,        // 10 MHz core clock
  input  wire logic          nrst_in,            // async reset, low
  input  wire ecs_wr_req_s   wr_req_in,          // software write
  input  wire logic          rd_en_in,           // software read
  input  wire logic          exc_taken_in,       // exception pulse
  input  wire ecs_exc_info_s exc_info_in,        // exception facts
  input  wire logic          interrupt_return_done_in,    // return done
  input  wire logic          interrupt_return_chained_in, // it chained
  input  wire logic          timer_irq_in,       // timer level
  input  wire logic          perf_irq_in,        // perf counter level
  input  wire logic [5:0]    hw_irq_in,          // hw pending levels
  input  wire logic          external_irq_controller_in,  // ext mode on
  input  wire logic [5:0]    requested_priority_level_in, // its level
  input  wire logic          boot_vector_in,     // boot vector flag
  output logic [31:0]        rd_data_out,        // read word
  output logic               rd_valid_out,       // read answer pulse
  output logic               count_match_irq_out,  // timer pending
  output logic               perf_counter_irq_out, // perf pending
  output logic               count_disable_out,  // stop count
  output logic [11:0]        irq_vector_out,     // dispatch offset
  output logic               vector_table_out    // vectored base
);

  // reset synchroniser: first stage feeds only the second
  logic rst_meta_reg;      // first stage
  logic rst_n_reg;         // released reset used everywhere

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // stored fields and their next values
  logic       delay_slot_flag_reg, delay_slot_flag_next;
  logic [1:0] cop_unit_reg, cop_unit_next;
  logic       count_disable_reg, count_disable_next;
  logic       chaining_happened_reg, chaining_happened_next;
  logic       auto_prologue_fault_reg, auto_prologue_fault_next;
  logic       vec_sel_reg, vec_sel_next;
  logic       wait_pend_reg, wait_pend_next;
  logic [1:0] sw_req_reg, sw_req_next;
  logic       timer_pend_reg, timer_pend_next;
  logic       perf_pend_reg, perf_pend_next;
  logic [5:0] hw_pend_reg, hw_pend_next;
  logic [31:0] rd_data_reg, rd_data_next;
  logic       rd_valid_reg, rd_valid_next;
  logic [11:0] vector_reg, vector_next;
  logic       table_reg, table_next;
  logic [31:0] word;        // live assembled register view

  // assemble the readable word; unused bits read zero
  always_comb begin
    word = WORD_RST;
    word[DELAY_SLOT_BIT] = delay_slot_flag_reg;
    word[TIMER_PEND_BIT] = timer_pend_reg;                // [RL4]
    word[COP_UNIT_HI:COP_UNIT_LO] = cop_unit_reg;
    word[COUNT_DIS_BIT] = count_disable_reg;
    word[PERF_PEND_BIT] = perf_pend_reg;                  // [RL8]
    word[CHAIN_BIT] = chaining_happened_reg;
    word[PROLOGUE_BIT] = auto_prologue_fault_reg;
    word[VEC_SEL_BIT] = vec_sel_reg;
    word[WAIT_PEND_BIT] = wait_pend_reg;
    word[HW_PEND_HI:HW_PEND_LO] = hw_pend_reg;
    word[SW_REQ_HI:SW_REQ_LO] = sw_req_reg;
  end

  // next-state of every field
  always_comb begin
    delay_slot_flag_next     = delay_slot_flag_reg;
    cop_unit_next            = cop_unit_reg;
    chaining_happened_next   = chaining_happened_reg;
    auto_prologue_fault_next = auto_prologue_fault_reg;
    count_disable_next       = count_disable_reg;
    vec_sel_next             = vec_sel_reg;
    wait_pend_next           = wait_pend_reg;
    sw_req_next              = sw_req_reg;
    // pending mirrors follow their sources one cycle late
    timer_pend_next = timer_irq_in;                       // [RL4]
    perf_pend_next  = perf_irq_in;                        // [RL8]
    // priority level replaces flags in controller mode
    if (external_irq_controller_in) begin
      hw_pend_next = requested_priority_level_in;         // [RL2]
    end else begin
      hw_pend_next = hw_irq_in;
    end
    // exception capture; software cannot touch these
    if (exc_taken_in) begin
      // nested exceptions keep the first slot indication
      if (!exc_info_in.level_was_set) begin
        delay_slot_flag_next = exc_info_in.in_delay_slot; // [RL3]
      end
      cop_unit_next            = exc_info_in.cop_unit;    // [RL6]
      auto_prologue_fault_next = exc_info_in.in_prologue; // [RL11]
    end
    // chaining result of each completed return
    if (interrupt_return_done_in) begin
      chaining_happened_next = interrupt_return_chained_in; // [RL10]
    end
    // software write touches only the writable fields
    if (wr_req_in.wr_en) begin                            // [RL1] [RL14]
      count_disable_next = wr_req_in.wr_data[COUNT_DIS_BIT]; // [RL7]
      vec_sel_next       = wr_req_in.wr_data[VEC_SEL_BIT];   // [RL12]
      wait_pend_next     = wr_req_in.wr_data[WAIT_PEND_BIT];
      sw_req_next        = wr_req_in.wr_data[SW_REQ_HI:SW_REQ_LO];
    end
    // read answer next cycle, sampled before any write lands
    rd_valid_next = rd_en_in;
    if (rd_en_in) begin
      rd_data_next = word;
    end else begin
      rd_data_next = rd_data_reg;
    end
    // vector choice from the stored select bit
    if (vec_sel_reg) begin
      vector_next = SPECIAL_VEC_OFFSET;                   // [RL12]
    end else begin
      vector_next = GEN_VEC_OFFSET;                       // [RL12]
    end
    table_next = vec_sel_reg && !boot_vector_in;          // [RL13]
  end

  // register every field; undefined-at-reset fields start at zero
  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      delay_slot_flag_reg     <= FLAG_RST;
      cop_unit_reg            <= COP_UNIT_RST;
      count_disable_reg       <= COUNT_DIS_RST;           // [RL7]
      chaining_happened_reg   <= FLAG_RST;
      auto_prologue_fault_reg <= FLAG_RST;
      vec_sel_reg             <= FLAG_RST;
      wait_pend_reg           <= FLAG_RST;
      sw_req_reg              <= SW_REQ_RST;
      timer_pend_reg          <= FLAG_RST;
      perf_pend_reg           <= PERF_PEND_RST;           // [RL8]
      hw_pend_reg             <= 6'h00;
      rd_data_reg             <= WORD_RST;
      rd_valid_reg            <= 1'b0;
      vector_reg              <= GEN_VEC_OFFSET;
      table_reg               <= 1'b0;
    end else begin
      delay_slot_flag_reg     <= delay_slot_flag_next;
      cop_unit_reg            <= cop_unit_next;
      count_disable_reg       <= count_disable_next;
      chaining_happened_reg   <= chaining_happened_next;
      auto_prologue_fault_reg <= auto_prologue_fault_next;
      vec_sel_reg             <= vec_sel_next;
      wait_pend_reg           <= wait_pend_next;
      sw_req_reg              <= sw_req_next;
      timer_pend_reg          <= timer_pend_next;
      perf_pend_reg           <= perf_pend_next;
      hw_pend_reg             <= hw_pend_next;
      rd_data_reg             <= rd_data_next;
      rd_valid_reg            <= rd_valid_next;
      vector_reg              <= vector_next;
      table_reg               <= table_next;
    end
  end

  // outputs straight from flops
  assign rd_data_out          = rd_data_reg;
  assign rd_valid_out         = rd_valid_reg;
  assign count_match_irq_out  = timer_pend_reg;           // [RL5]
  assign perf_counter_irq_out = perf_pend_reg;            // [RL9]
  assign count_disable_out    = count_disable_reg;        // [RL7]
  assign irq_vector_out       = vector_reg;
  assign vector_table_out     = table_reg;

  // checks on the block's own registers and outputs
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_reg);

  chk_wr_fields_only: assert property ( // [RL1]
    wr_req_in.wr_en && !exc_taken_in && !interrupt_return_done_in |=>
      count_disable_reg == $past(wr_req_in.wr_data[COUNT_DIS_BIT]) &&
      sw_req_reg == $past(wr_req_in.wr_data[SW_REQ_HI:SW_REQ_LO]))
    else $error("writable field did not take written value");
  chk_ro_write_ignored: assert property ( // [RL14]
    wr_req_in.wr_en && !exc_taken_in && !interrupt_return_done_in |=>
      $stable(delay_slot_flag_reg) && $stable(cop_unit_reg) &&
      $stable(chaining_happened_reg))
    else $error("write altered a read-only field");
  chk_ext_level_shown: assert property ( // [RL2]
    external_irq_controller_in ##1 rd_en_in |=>
      rd_data_out[HW_PEND_HI:HW_PEND_LO] ==
        $past(requested_priority_level_in, 2))
    else $error("priority level not shown in controller mode");
  chk_delay_slot_hold: assert property ( // [RL3]
    exc_taken_in && exc_info_in.level_was_set |=>
      $stable(delay_slot_flag_reg))
    else $error("delay slot flag changed with level set");
  chk_delay_slot_load: assert property ( // [RL3]
    exc_taken_in && !exc_info_in.level_was_set |=>
      delay_slot_flag_reg == $past(exc_info_in.in_delay_slot))
    else $error("delay slot flag not captured");
  chk_timer_mirror: assert property ( // [RL4] [RL5]
    timer_irq_in |=> count_match_irq_out ##0 !rd_valid_out ||
      rd_data_out[TIMER_PEND_BIT] == $past(timer_irq_in, 2))
    else $error("timer pending output wrong");
  chk_cop_unit_load: assert property ( // [RL6]
    exc_taken_in |=> cop_unit_reg == $past(exc_info_in.cop_unit))
    else $error("unit number not loaded");
  chk_count_stop: assert property ( // [RL7]
    wr_req_in.wr_data[COUNT_DIS_BIT] && wr_req_in.wr_en |=>
      count_disable_out [*1] ##1 (count_disable_out || $past(wr_req_in.wr_en)))
    else $error("count disable not held");
  chk_perf_mirror: assert property ( // [RL8] [RL9]
    $rose(perf_irq_in) |=> perf_counter_irq_out ##1
      (perf_counter_irq_out == $past(perf_irq_in)))
    else $error("perf pending output wrong");
  chk_chain_record: assert property ( // [RL10]
    interrupt_return_done_in |=>
      chaining_happened_reg == $past(interrupt_return_chained_in))
    else $error("chaining result not recorded");
  chk_prologue_record: assert property ( // [RL11]
    exc_taken_in |=> auto_prologue_fault_reg == $past(exc_info_in.in_prologue))
    else $error("prologue fault not recorded");
  chk_vector_offset: assert property ( // [RL12]
    vec_sel_reg |=> irq_vector_out == SPECIAL_VEC_OFFSET)
    else $error("vector offset does not follow select bit");
  chk_table_base: assert property ( // [RL13]
    vec_sel_reg && !boot_vector_in |=> vector_table_out)
    else $error("vectored table base not flagged");
  chk_vector_general: assert property ( // [RL12]
    !vec_sel_reg |=> irq_vector_out == GEN_VEC_OFFSET)
    else $error("general vector not used with select clear");
  chk_table_clear: assert property ( // [RL13]
    !vec_sel_reg || boot_vector_in |=> !vector_table_out)
    else $error("vectored table base flagged wrongly");

  cov_exc_slot: cover property (exc_taken_in && exc_info_in.in_delay_slot);
  cov_chained: cover property (interrupt_return_done_in &&
    interrupt_return_chained_in);
  cov_ext_read: cover property (external_irq_controller_in ##1 rd_en_in);
  cov_vec_table: cover property ($rose(vector_table_out));

endmodule // ecs_cause
`default_nettype wire

// >>> tb/ecs_cause_tb_top.sv
// self-checking bench for the exception cause status register
`default_nettype none
module ecs_cause_tb_top
  import ecs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          core_clk;      // 100 ns period
  logic          nrst;          // raw reset, low active
  ecs_wr_req_s   wr_req;        // software write
  logic          rd_en;         // software read
  logic          exc_taken;     // exception pulse
  ecs_exc_info_s exc_info;      // facts with the pulse
  logic          ret_done;      // return pulse
  logic          ret_chained;   // chained flag
  logic          timer_irq;     // timer level
  logic          perf_irq;      // perf level
  logic [5:0]    hw_irq;        // hardware pending levels
  logic          ext_ctrl;      // external controller mode
  logic [5:0]    prio_level;    // requested priority level
  logic          boot_vec;      // boot vector flag
  logic [31:0]   rd_data;       // read word
  logic          rd_valid;      // read answer
  logic          cm_irq;        // timer mirror
  logic          pc_irq;        // perf mirror
  logic          cnt_dis;       // count stop
  logic [11:0]   irq_vec;       // dispatch offset
  logic          vec_tab;       // vectored table base
  int            failures = 0;  // mismatches
  int            check_count = 0; // comparisons
  ecs_cause uut (.core_clk_in(core_clk), .nrst_in(nrst), .wr_req_in(wr_req),
    .rd_en_in(rd_en), .exc_taken_in(exc_taken), .exc_info_in(exc_info),
    .interrupt_return_done_in(ret_done),
    .interrupt_return_chained_in(ret_chained),
    .timer_irq_in(timer_irq), .perf_irq_in(perf_irq), .hw_irq_in(hw_irq),
    .external_irq_controller_in(ext_ctrl),
    .requested_priority_level_in(prio_level), .boot_vector_in(boot_vec),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .count_match_irq_out(cm_irq), .perf_counter_irq_out(pc_irq),
    .count_disable_out(cnt_dis), .irq_vector_out(irq_vec),
    .vector_table_out(vec_tab));
  // free running core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // compare and count, four-state exact
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one read; answer pulse must last exactly one cycle
  task automatic rdchk(input logic [31:0] e);
    @(posedge core_clk) rd_en <= 1'b1;
    @(posedge core_clk) rd_en <= 1'b0;
    @(negedge core_clk) chk("rd_valid", 32'h1, 32'(rd_valid));
    chk("cause word", e, rd_data);
    @(negedge core_clk) chk("rd_valid end", 32'h0, 32'(rd_valid));
  endtask
  // one write strobe
  task automatic wr(input logic [31:0] d);
    @(posedge core_clk);
    wr_req.wr_en <= 1'b1;
    wr_req.wr_data <= d;
    @(posedge core_clk) wr_req.wr_en <= 1'b0;
  endtask
  // one exception pulse with its facts
  task automatic exc(input ecs_exc_info_s i);
    @(posedge core_clk);
    exc_taken <= 1'b1;
    exc_info <= i;
    @(posedge core_clk) exc_taken <= 1'b0;
  endtask
  // one interrupt return pulse
  task automatic int_ret(input logic ch);
    @(posedge core_clk);
    ret_done <= 1'b1;
    ret_chained <= ch;
    @(posedge core_clk) ret_done <= 1'b0;
  endtask
  // report counts and verdict, then stop
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // reset state of outputs and word
  task automatic s_reset();
    chk("count disable", 32'h0, 32'(cnt_dis));
    chk("vector", 32'h180, 32'(irq_vec));
    chk("timer out", 32'h0, 32'(cm_irq));
    rdchk(32'h0);
  endtask
  // pending mirrors, then priority reading in controller mode
  task automatic s_pending();
    @(posedge core_clk);
    timer_irq <= 1'b1;
    perf_irq <= 1'b1;
    hw_irq <= 6'h2a;
    @(posedge core_clk);
    @(negedge core_clk) chk("timer out", 32'h1, 32'(cm_irq));
    chk("perf out", 32'h1, 32'(pc_irq));
    rdchk(32'h4400_a800);
    @(posedge core_clk);
    ext_ctrl <= 1'b1;
    prio_level <= 6'h15;
    rdchk(32'h4400_5400);
    @(posedge core_clk) perf_irq <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk) chk("timer out", 32'h1, 32'(cm_irq));
    chk("perf out", 32'h0, 32'(pc_irq));
    @(posedge core_clk);
    {timer_irq, perf_irq, ext_ctrl, hw_irq, prio_level} <= '0;
    rdchk(32'h0);
    chk("perf out", 32'h0, 32'(pc_irq));
  endtask
  // writable controls and what they drive
  task automatic s_control();
    wr(32'hffff_ffff);
    rdchk(32'h08c0_0300);
    chk("count disable", 32'h1, 32'(cnt_dis));
    chk("vector", 32'h200, 32'(irq_vec));
    chk("table base", 32'h1, 32'(vec_tab));
    @(posedge core_clk) boot_vec <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) chk("table base", 32'h0, 32'(vec_tab));
    @(posedge core_clk) boot_vec <= 1'b0;
    wr(32'h0);
    rdchk(32'h0);
    chk("count disable", 32'h0, 32'(cnt_dis));
    chk("vector", 32'h180, 32'(irq_vec));
  endtask
  // exception facts; delay slot frozen while level is set
  task automatic s_exception();
    exc('{1'b1, 1'b0, 2'h3, 1'b1});
    rdchk(32'hb100_0000);
    exc('{1'b0, 1'b1, 2'h1, 1'b0});
    rdchk(32'h9000_0000);
    wr(32'hffff_ffff);
    rdchk(32'h98c0_0300);
    wr(32'h0);
  endtask
  // chaining record on interrupt return
  task automatic s_return();
    int_ret(1'b1);
    rdchk(32'h9200_0000);
    int_ret(1'b0);
    rdchk(32'h9000_0000);
  endtask
  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    wr_req = '0;
    {rd_en, exc_taken, ret_done, ret_chained, timer_irq} = '0;
    {perf_irq, ext_ctrl, boot_vec, hw_irq, prio_level} = '0;
    exc_info = '0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    s_reset();
    s_pending();
    s_control();
    s_exception();
    s_return();
    finish_test();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    finish_test();
  end
endmodule // ecs_cause_tb_top
`default_nettype wire
